//--- rtl/cpu_subset_exec.sv
// Instruction subset core: fetch, decode and execute with a Wishbone register window
// Behaviour
// - Debug trap saves PC+2 and status, then sets nmi, exception, mask flags
// - Debug trap then jumps to vector 0x60, taking 3 clocks
// - Mask-interrupts sets the interrupt mask flag in 1 clock
// - Unmask-interrupts clears the interrupt mask flag in 1 clock
// - Halt stops execution, counted as a 1-clock instruction
// - Frame release adds size field times four to SP, then pops listed registers
// - Frame release takes n+1 clocks; reg1 form jumps to reg1 in n+3
// - Signed word divide: quotient to reg2, remainder to reg3, 35 clocks, flags
// - Two-operand signed halfword divide replaces reg2 with quotient, 35 clocks
// - Three-operand signed halfword divide: quotient reg2, remainder reg3, 35 clocks
// - Unsigned halfword divide: quotient reg2, remainder reg3, 34 clocks, flags
// - Unsigned word divide: quotient reg2, remainder reg3, 34 clocks, flags
// - Halfword swap writes reg3 in 1 clock, sets carry sign zero, clears overflow
// - Branch-and-link stores PC+4 in reg2, adds 22-bit displacement, 2 clocks
// - Register branch loads PC from reg1 in 3; relative branch adds displacement in 2
// - Signed byte load from reg1 plus displacement, sign-extended into reg2
// - Unsigned byte load from reg1 plus displacement, zero-extended into reg2
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_cfg.svh"
module cpu_subset_exec #(
  parameter logic [31:0] RESET_PC = `RESET_PC,
  parameter logic [31:0] IRQ_VECTOR = `IRQ_VECTOR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire cpu_subset_pkg::wb_req_s wb_req,
  output var cpu_subset_pkg::wb_rsp_s wb_rsp,
  // Program and data memory
  output var cpu_subset_pkg::mem_req_s mem_req,
  input wire cpu_subset_pkg::mem_rsp_s mem_rsp,
  // Interrupt request and run state
  input wire logic irq_req,
  output logic halted
);
  import cpu_subset_pkg::*;

  core_s s_r;
  core_s s_nxt;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Opcode decode of a fetched word, first halfword in the low bits
  function automatic op_e decode(input logic [31:0] w);
    logic [15:0] h1;
    logic [15:0] h2;
    op_e o;
    h1 = w[15:0];
    h2 = w[31:16];
    o = OP_NOP;
    if (h1 == `OPC_DEBUG_TRAP) begin
      o = OP_DTRAP;
    end else if (h1[15:5] == `MAJ_REGJ) begin
      o = OP_REGJ;
    end else if (h1[15:6] == `MAJ_DISP) begin
      o = OP_DISP;
    end else if (h1[10:5] == `MAJ_HDIV2) begin
      o = OP_DIVH2;
    end else if (h1[10:5] == `MAJ_LDB) begin
      o = OP_LDB;
    end else if (h1[10:6] == `MAJ_LINK) begin
      o = h2[0] ? OP_LDB : OP_LINK;
    end else if (h1[10:5] == `MAJ_EXT) begin
      if (h2[10:0] == `SUB_INTMASK && h1 == `OPC_MASK_H1) begin
        o = OP_MASK;
      end else if (h2[10:0] == `SUB_INTMASK && h1 == `OPC_UNMASK_H1) begin
        o = OP_UNMASK;
      end else if (h2[10:0] == `SUB_HALT) begin
        o = OP_HALT;
      end else if (h2[10:0] == `SUB_DIV) begin
        o = OP_DIV;
      end else if (h2[10:0] == `SUB_SHDIV) begin
        o = OP_SHDIV3;
      end else if (h2[10:0] == `SUB_UHDIV) begin
        o = OP_UHDIV;
      end else if (h2[10:0] == `SUB_UWDIV) begin
        o = OP_UWDIV;
      end else if (h2[10:0] == `SUB_SWAP) begin
        o = OP_SWAP;
      end
    end
    return o;
  endfunction : decode

  // Execution clocks per operation
  function automatic logic [5:0] cycles(input op_e o);
    case (o)
      OP_DTRAP, OP_REGJ: cycles = `CYC_THREE;
      OP_DIV, OP_DIVH2, OP_SHDIV3: cycles = `CYC_SDIV;
      OP_UHDIV, OP_UWDIV: cycles = `CYC_UDIV;
      OP_LINK: cycles = `CYC_JUMP;
      default: cycles = `CYC_ONE;
    endcase
  endfunction : cycles

  // Bus and memory outputs come straight from the state
  assign wb_rsp.ack = s_r.ack;
  assign wb_rsp.dat = s_r.rdat;
  assign mem_req.cyc = (s_r.st == ST_FETCH) || (s_r.st == ST_LOAD) || (s_r.st == ST_POP);
  assign mem_req.adr = s_r.madr;
  assign halted = (s_r.st == ST_HALT);

  // Next-state logic of bus window, sequencer and datapath
  always_comb begin
    logic [15:0] h1;
    logic [15:0] h2;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [31:0] a;
    logic [31:0] dvs;
    logic [31:0] q;
    logic [31:0] rm;
    logic [31:0] npc;
    logic [31:0] sw;
    logic [4:0] idx;
    logic dov;
    logic dwr;
    logic fnd;
    logic pop_done;
    op_e fop;
    s_nxt = s_r;
    h1 = s_r.ins[15:0];
    h2 = s_r.ins[31:16];
    f1 = mem_rsp.dat[15:0];
    f2 = mem_rsp.dat[31:16];
    a = s_r.gr[h1[15:11]];
    npc = s_r.pc + 32'd4;
    sw = {s_r.gr[h1[15:11]][15:0], s_r.gr[h1[15:11]][31:16]};
    idx = `LIST_BASE;
    fnd = 1'b0;
    pop_done = 1'b0;
    fop = decode(mem_rsp.dat);
    // Divider operands and results, halfword forms extend the low divisor half
    if (s_r.op == OP_SHDIV3 || s_r.op == OP_DIVH2) begin
      dvs = {{16{s_r.gr[h1[4:0]][15]}}, s_r.gr[h1[4:0]][15:0]};
    end else if (s_r.op == OP_UHDIV) begin
      dvs = {16'h0000, s_r.gr[h1[4:0]][15:0]};
    end else begin
      dvs = s_r.gr[h1[4:0]];
    end
    dov = 1'b0;
    dwr = 1'b1;
    q = a;
    rm = 32'h0000_0000;
    if (dvs == 32'h0000_0000) begin
      dov = 1'b1;
      dwr = 1'b0;
    end else if (!s_r.uns && a == 32'h8000_0000 && dvs == 32'hffff_ffff) begin
      dov = 1'b1;
    end else if (!s_r.uns) begin
      q = 32'($signed(a) / $signed(dvs));
      rm = 32'($signed(a) % $signed(dvs));
    end else begin
      q = a / dvs;
      rm = a % dvs;
    end
    // Wishbone slave: one access answered one cycle after the strobe
    s_nxt.ack = 1'b0;
    if (wb_req.cyc && wb_req.stb && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdat = 32'h0000_0000;
      if (wb_req.adr[7:0] == `OFS_STATUS) begin
        s_nxt.rdat = {24'h000000, s_r.stat};
      end else if (wb_req.adr[7:0] == `OFS_PC) begin
        s_nxt.rdat = s_r.pc;
        if (wb_req.we && s_r.st == ST_HALT) begin
          s_nxt.pc = merge(s_r.pc, wb_req.dat, wb_req.sel);
        end
      end else if (wb_req.adr[7:0] == `OFS_DBG_PC) begin
        s_nxt.rdat = s_r.debug_saved_pc;
      end else if (wb_req.adr[7:0] == `OFS_DBG_STATUS) begin
        s_nxt.rdat = {24'h000000, s_r.dbstat};
      end else if (wb_req.adr[7:0] == `OFS_STATE) begin
        s_nxt.rdat = {30'h0, s_r.st != ST_HALT, s_r.st == ST_HALT};
      end else if (wb_req.adr[7:0] == `OFS_GR_SEL) begin
        s_nxt.rdat = {27'h0, s_r.gsel};
        if (wb_req.we && wb_req.sel[0]) begin
          s_nxt.gsel = wb_req.dat[4:0];
        end
      end else if (wb_req.adr[7:0] == `OFS_GR_DATA) begin
        s_nxt.rdat = s_r.gr[s_r.gsel];
        if (wb_req.we) begin
          s_nxt.gr[s_r.gsel] = merge(s_r.gr[s_r.gsel], wb_req.dat, wb_req.sel);
        end
      end
    end
    // Sequencer; flags not named by an operation keep their value
    case (s_r.st)
      ST_FETCH: begin
        if (mem_rsp.ack) begin
          s_nxt.ins = mem_rsp.dat;
          s_nxt.op = fop;
          s_nxt.uns = (fop == OP_UHDIV) || (fop == OP_UWDIV);
          s_nxt.cnt = cycles(fop);
          s_nxt.st = ST_EXEC;
          if (fop == OP_LDB) begin
            s_nxt.st = ST_LOAD;
            s_nxt.madr = s_r.gr[f1[4:0]] + (f1[10:5] == `MAJ_LDB ? {{16{f2[15]}}, f2} :
                         {{16{f2[15]}}, f2[15:1], f1[5]});
          end
        end
      end
      ST_EXEC: begin
        if (s_r.cnt > `CYC_ONE) begin
          s_nxt.cnt = s_r.cnt - `CYC_ONE;
        end else begin
          s_nxt.st = ST_FETCH;
          case (s_r.op)
            OP_DTRAP: begin
              s_nxt.debug_saved_pc = s_r.pc + 32'd2;
              s_nxt.dbstat = s_r.stat;
              s_nxt.stat.nmi_pend = 1'b1;
              s_nxt.stat.exc_act = 1'b1;
              s_nxt.stat.int_mask = 1'b1;
              npc = `DBG_VECTOR;
            end
            OP_MASK: s_nxt.stat.int_mask = 1'b1;
            OP_UNMASK: s_nxt.stat.int_mask = 1'b0;
            OP_HALT: s_nxt.st = ST_HALT;
            OP_DISP: begin
              s_nxt.gr[`SP_IDX] = s_r.gr[`SP_IDX] + {25'h0, h1[5:1], 2'b00};
              s_nxt.madr = s_r.gr[`SP_IDX] + {25'h0, h1[5:1], 2'b00};
              s_nxt.list = {h2[15:5], h1[0]};
              s_nxt.st = ST_POP;
              pop_done = ({h2[15:5], h1[0]} == 12'h000);
            end
            OP_DRET: npc = s_r.gr[h2[4:0]];
            OP_DIV, OP_SHDIV3, OP_UHDIV, OP_UWDIV, OP_DIVH2: begin
              if (dwr && s_r.op != OP_DIVH2) begin
                s_nxt.gr[h2[15:11]] = rm;
              end
              if (dwr) begin
                s_nxt.gr[h1[15:11]] = q;
              end
              s_nxt.stat.excess = dov;
              s_nxt.stat.s = q[31];
              s_nxt.stat.z = (q == 32'h0000_0000);
              if (s_r.op == OP_DIVH2) begin
                npc = s_r.pc + 32'd2;
              end
            end
            OP_SWAP: begin
              s_nxt.gr[h2[15:11]] = sw;
              s_nxt.stat.carry = (a[15:0] == 16'h0000) || (a[31:16] == 16'h0000);
              s_nxt.stat.excess = 1'b0;
              s_nxt.stat.s = sw[31];
              s_nxt.stat.z = (sw == 32'h0000_0000);
            end
            OP_LINK: begin
              s_nxt.gr[h1[15:11]] = s_r.pc + 32'd4;
              npc = s_r.pc + {{10{h1[5]}}, h1[5:0], h2[15:1], 1'b0};
            end
            OP_REGJ: npc = s_r.gr[h1[4:0]];
            default: npc = s_r.pc + 32'd2;
          endcase
          if (s_r.op != OP_DISP) begin
            s_nxt.pc = npc;
            s_nxt.madr = npc;
          end
        end
      end
      ST_LOAD: begin
        if (mem_rsp.ack) begin
          s_nxt.gr[h1[15:11]] = {{24{mem_rsp.dat[7] && h1[10:5] == `MAJ_LDB}},
                                 mem_rsp.dat[7:0]};
          s_nxt.pc = npc;
          s_nxt.madr = npc;
          s_nxt.st = ST_FETCH;
        end
      end
      ST_POP: begin
        // Lowest listed register is restored first, one word per answer
        for (int i = 0; i < 12; i++) begin
          if (s_r.list[i] && !fnd) begin
            fnd = 1'b1;
            idx = `LIST_BASE + 5'(i);
            s_nxt.list[i] = 1'b0;
          end
        end
        if (mem_rsp.ack) begin
          s_nxt.gr[idx] = mem_rsp.dat;
          s_nxt.gr[`SP_IDX] = s_r.gr[`SP_IDX] + 32'd4;
          s_nxt.madr = s_r.gr[`SP_IDX] + 32'd4;
          pop_done = (s_nxt.list == 12'h000);
        end else begin
          s_nxt.list = s_r.list;
        end
      end
      ST_HALT: begin
        if (irq_req && !s_r.stat.int_mask && !s_r.stat.nmi_pend) begin
          s_nxt.stat.int_mask = 1'b1;
          s_nxt.pc = IRQ_VECTOR;
          s_nxt.madr = IRQ_VECTOR;
          s_nxt.st = ST_FETCH;
        end
      end
      default: s_nxt.st = ST_FETCH;
    endcase
    // After the last restore: fetch on, or two more clocks for the jump form
    if (pop_done) begin
      if (h2[4:0] != 5'h00) begin
        s_nxt.op = OP_DRET;
        s_nxt.cnt = `CYC_DRET;
        s_nxt.st = ST_EXEC;
      end else begin
        s_nxt.pc = npc;
        s_nxt.madr = npc;
        s_nxt.st = ST_FETCH;
      end
    end
    s_nxt.gr[0] = 32'h0000_0000;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= ST_FETCH;
      s_r.op <= OP_NOP;
      s_r.pc <= RESET_PC;
      s_r.madr <= RESET_PC;
      s_r.stat <= `STATUS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : cpu_subset_exec
`default_nettype wire

//--- rtl/cpu_subset_cfg.svh
// Offsets, opcode fields, reset values and clock counts of the instruction subset core
`ifndef CPU_SUBSET_CFG_SVH
`define CPU_SUBSET_CFG_SVH
// Register bus offsets (byte addresses)
`define OFS_STATUS 8'h00
`define OFS_PC 8'h04
`define OFS_DBG_PC 8'h08
`define OFS_DBG_STATUS 8'h0c
`define OFS_STATE 8'h10
`define OFS_GR_SEL 8'h14
`define OFS_GR_DATA 8'h18
// Reset values and vectors
`define RESET_PC 32'h0000_0000
`define IRQ_VECTOR 32'h0000_0080
`define DBG_VECTOR 32'h0000_0060
`define STATUS_RESET 8'h00
// Opcode patterns
`define OPC_DEBUG_TRAP 16'hf840
`define OPC_MASK_H1 16'h07e0
`define OPC_UNMASK_H1 16'h87e0
`define MAJ_EXT 6'h3f
`define MAJ_HDIV2 6'h02
`define MAJ_LDB 6'h38
`define MAJ_LINK 5'h1e
`define MAJ_DISP 10'h019
`define MAJ_REGJ 11'h003
`define SUB_INTMASK 11'h160
`define SUB_HALT 11'h120
`define SUB_DIV 11'h2c0
`define SUB_SHDIV 11'h280
`define SUB_UHDIV 11'h282
`define SUB_UWDIV 11'h2c2
`define SUB_SWAP 11'h344
// Register numbers
`define SP_IDX 5'd3
`define LIST_BASE 5'd20
// Execution clock counts
`define CYC_ONE 6'd1
`define CYC_JUMP 6'd2
`define CYC_DRET 6'd2
`define CYC_THREE 6'd3
`define CYC_SDIV 6'd35
`define CYC_UDIV 6'd34
`endif

//--- rtl/cpu_subset_pkg.sv
// Types of the instruction subset core: states, operations, status word and bus carriers
package cpu_subset_pkg;
  typedef enum logic [2:0] {ST_FETCH, ST_EXEC, ST_LOAD, ST_POP, ST_HALT} state_e;
  typedef enum logic [3:0] {
    OP_NOP, OP_DTRAP, OP_MASK, OP_UNMASK, OP_HALT, OP_DISP, OP_DRET, OP_DIV, OP_DIVH2,
    OP_SHDIV3, OP_UHDIV, OP_UWDIV, OP_SWAP, OP_LINK, OP_REGJ, OP_LDB
  } op_e;
  typedef struct packed {
    logic nmi_pend;
    logic exc_act;
    logic int_mask;
    logic saturate;
    logic carry;
    logic excess;
    logic s;
    logic z;
  } status_s;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;
  typedef struct packed {
    logic cyc;
    logic [31:0] adr;
  } mem_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mem_rsp_s;
  typedef struct packed {
    state_e st;
    op_e op;
    logic uns;
    logic [5:0] cnt;
    logic [31:0] pc;
    logic [31:0] ins;
    status_s stat;
    logic [31:0] debug_saved_pc;
    status_s dbstat;
    logic [11:0] list;
    logic [31:0] madr;
    logic [4:0] gsel;
    logic ack;
    logic [31:0] rdat;
    logic [31:0][31:0] gr;
  } core_s;
endpackage : cpu_subset_pkg

//--- testbench/cpu_subset_chk.sv
// Port-level assertions for the instruction subset core
`timescale 1ns/1ps
`default_nettype none
module cpu_subset_chk #(
  parameter logic [31:0] RESET_PC = 32'h0000_0000,
  parameter logic [31:0] IRQ_VECTOR = 32'h0000_0080
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire cpu_subset_pkg::wb_req_s wb_req,
  input wire cpu_subset_pkg::wb_rsp_s wb_rsp,
  // Memory port
  input wire cpu_subset_pkg::mem_req_s mem_req,
  input wire cpu_subset_pkg::mem_rsp_s mem_rsp,
  // Interrupt and run state
  input wire logic irq_req,
  input wire logic halted
);
  import cpu_subset_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Register bus answers once, one cycle after the take
  a_ack_once: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus ack is not a single pulse after the request");
  a_ack_cause: assert property (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
    else $error("bus ack without a request");
  // Memory request holds until answered
  a_mem_hold: assert property (mem_req.cyc && !mem_rsp.ack |=> mem_req.cyc && $stable(mem_req.adr))
    else $error("memory request changed before its answer");
  // Halted core stays quiet until an interrupt
  a_halt_quiet: assert property (halted |-> !mem_req.cyc)
    else $error("memory access while halted");
  a_halt_stays: assert property (halted && !irq_req |=> halted && $stable(mem_req.adr))
    else $error("halt left or address moved without interrupt");
  a_irq_resume: assert property ($fell(halted) |-> $past(irq_req) && mem_req.cyc && mem_req.adr == IRQ_VECTOR)
    else $error("halt left other than by interrupt to its vector");
  a_halt_entry: assert property ($rose(halted) |-> !$past(mem_req.cyc) && $past(mem_req.cyc, 2))
    else $error("halt entry is not one cycle after its fetch");
  // Fetch starts at the reset address right after reset
  a_reset_fetch: assert property ($fell(sys_rst) |-> mem_req.cyc && mem_req.adr == RESET_PC && !halted)
    else $error("no fetch from the reset address after reset");
endmodule : cpu_subset_chk
`default_nettype wire

//--- testbench/mem_model.sv
// Program and data memory with selectable wait states
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Memory port
  input wire cpu_subset_pkg::mem_req_s mem_req,
  output var cpu_subset_pkg::mem_rsp_s mem_rsp,
  // Wait states before each answer
  input wire logic [1:0] wait_n
);
  import cpu_subset_pkg::*;
  logic [7:0] mem [512];
  logic [1:0] cnt_r;
  logic [8:0] a;
  logic [31:0] word;
  // Unaligned word from the byte address; inverted data outside the answer
  always_comb begin
    a = mem_req.adr[8:0];
    word = {mem[a + 9'h3], mem[a + 9'h2], mem[a + 9'h1], mem[a]};
    mem_rsp.ack = mem_req.cyc && (cnt_r == wait_n) && (mem_req.adr[31:9] == 23'h000000);
    mem_rsp.dat = mem_rsp.ack ? word : ~word;
  end
  // Wait counter restarts after each answer
  always_ff @(posedge core_clk) begin
    cnt_r <= (sys_rst || !mem_req.cyc || mem_rsp.ack) ? 2'h0 : cnt_r + 2'h1;
  end
endmodule : mem_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the instruction subset core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_subset_cfg.svh"
module tb;
  import cpu_subset_pkg::*;
  localparam logic [31:0] H = 32'h012007e0;
  typedef struct {
    logic [63:0] code;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [7:0] a [3];
    logic [31:0] e [3];
    int n;
  } row_s;
  logic core_clk;
  logic sys_rst;
  logic irq_req;
  logic halted;
  logic [1:0] wait_n;
  wb_req_s wb_req;
  wb_rsp_s wb_rsp;
  mem_req_s mem_req;
  mem_rsp_s mem_rsp;
  int failures;
  int cmp_count;
  // Code words, reg1, reg2, places to read, values expected, clocks
  row_s rows [17] = '{
    '{{H, 32'h016087e0}, 32'h0, 32'h0, '{8'h00, 8'h82, 8'h81}, '{32'h0, 32'h0, 32'h0}, 1},
    '{{32'h016007e0, 32'h016087e0}, 32'h0, 32'h0, '{8'h00, 8'h82, 8'h81},
      '{32'h20, 32'h0, 32'h0}, 0},
    '{{H, 32'h234417e0}, 32'h0, 32'h12345678, '{8'h84, 8'h00, 8'h82},
      '{32'h56781234, 32'h20, 32'h12345678}, 1},
    '{{H, 32'h234417e0}, 32'h0, 32'h0000ffff, '{8'h84, 8'h00, 8'h82},
      '{32'hffff0000, 32'h2a, 32'h0000ffff}, 1},
    '{{H, 32'h22c017e1}, 32'h7, 32'hffffff9c, '{8'h82, 8'h84, 8'h00},
      '{32'hfffffff2, 32'hfffffffe, 32'h22}, 35},
    '{{H, 32'h228017e1}, 32'h7, 32'hffffff9c, '{8'h82, 8'h84, 8'h00},
      '{32'hfffffff2, 32'hfffffffe, 32'h22}, 35},
    '{{H, 32'h228217e1}, 32'h7, 32'hffffff9c, '{8'h82, 8'h84, 8'h00},
      '{32'h24924916, 32'h2, 32'h20}, 34},
    '{{H, 32'h22c217e1}, 32'h7, 32'hffffff9c, '{8'h82, 8'h84, 8'h00},
      '{32'h24924916, 32'h2, 32'h20}, 34},
    '{{32'h00000120, 32'h07e01041}, 32'h7, 32'h64, '{8'h82, 8'h84, 8'h00},
      '{32'he, 32'h0, 32'h20}, 35},
    '{{H, 32'h00101780}, 32'h0, 32'h0, '{8'h82, 8'h04, 8'h00},
      '{32'h84, 32'h94, 32'h20}, 2},
    '{{H, 32'hff8007bf}, 32'h0, 32'h0, '{8'h04, 8'h82, 8'h00}, '{32'h4, 32'h0, 32'h20}, 2},
    '{{H, 32'h07e00061}, 32'ha0, 32'h0, '{8'h04, 8'h81, 8'h00},
      '{32'ha4, 32'ha0, 32'h20}, 3},
    '{{H, 32'hfffd1701}, 32'h104, 32'h0, '{8'h82, 8'h81, 8'h00},
      '{32'hffffff92, 32'h104, 32'h20}, 0},
    '{{H, 32'hfffd17a1}, 32'h104, 32'h0, '{8'h82, 8'h81, 8'h00},
      '{32'h92, 32'h104, 32'h20}, 0},
    '{{H, 32'h00200645}, 32'h0, 32'h0, '{8'h94, 8'h95, 8'h83},
      '{32'hd8d9dadb, 32'hdcdddedf, 32'h150}, 3},
    '{{H, 32'h00210645}, 32'ha0, 32'h0, '{8'h04, 8'h83, 8'h95},
      '{32'ha4, 32'h150, 32'hdcdddedf}, 5},
    '{{H, 32'h07e0f840}, 32'h0, 32'h0, '{8'h08, 8'h0c, 8'h04},
      '{32'h82, 32'h20, 32'h64}, 3}
  };
  cpu_subset_exec cpu_subset_exec_i (.core_clk(core_clk), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp), .irq_req(irq_req), .halted(halted));
  mem_model mem_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .wait_n(wait_n));
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic tmo(input int i, input int lim);
    if (i == lim) begin
      failures++;
      wrap_up();
    end
  endtask : tmo
  // One classic Wishbone cycle, released at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    wb_req <= '{1'b1, 1'b1, w, {24'h0, a}, 4'hf, d};
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (wb_rsp.ack === 1'b1) break;
    end
    tmo(i, 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge core_clk);
  endtask : wb
  task automatic setgr(input logic [4:0] r, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, `OFS_GR_SEL, {27'h0, r}, q);
    wb(1'b1, `OFS_GR_DATA, d, q);
  endtask : setgr
  // Top bit of the place selects a general register
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    if (a[7]) begin
      wb(1'b1, `OFS_GR_SEL, {27'h0, a[4:0]}, q);
      wb(1'b0, `OFS_GR_DATA, 32'h0, q);
    end else begin
      wb(1'b0, a, 32'h0, q);
    end
    cmp($sformatf("reg_%h", a), e, q);
  endtask : chk
  task automatic rst();
    int i;
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (halted === 1'b1) break;
    end
    tmo(i, 20);
  endtask : rst
  // Wake the core and count the cycles until it halts again
  task automatic run(output int c);
    int i;
    irq_req <= 1'b1;
    @(posedge core_clk);
    irq_req <= 1'b0;
    c = 0;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (halted === 1'b0) c++;
      else if (c > 0) break;
    end
    tmo(i, 200);
    @(posedge core_clk);
  endtask : run
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Main sequence: table rows, then halt, reset and unmapped cases
  initial begin
    int i;
    int j;
    int c;
    logic [31:0] q;
    sys_rst = 1'b1;
    irq_req = 1'b0;
    wait_n = 2'h0;
    wb_req = '0;
    failures = 0;
    cmp_count = 0;
    for (i = 0; i < 512; i++) mem_model_i.mem[i] = (i < 256) ? H[8 * (i % 4) +: 8] : 8'(i) ^ 8'h93;
    foreach (rows[k]) begin
      rst();
      for (j = 0; j < 8; j++) mem_model_i.mem[128 + j] = rows[k].code[8 * j +: 8];
      wait_n <= (rows[k].n == 0) ? 2'h2 : 2'h0;
      setgr(5'd1, rows[k].r1);
      setgr(5'd2, rows[k].r2);
      setgr(5'd3, 32'h140);
      run(c);
      if (rows[k].n > 0) cmp("cycles", 32'(rows[k].n + 3), 32'(c));
      for (j = 0; j < 3; j++) chk(rows[k].a[j], rows[k].e[j]);
    end
    chk(8'h00, 32'he0);
    irq_req <= 1'b1;
    repeat (8) @(posedge core_clk);
    irq_req <= 1'b0;
    cmp("halted", 32'h1, {31'h0, halted});
    chk(8'h04, 32'h64);
    rst();
    chk(8'h00, 32'h0);
    chk(8'h08, 32'h0);
    chk(8'h0c, 32'h0);
    chk(8'h10, 32'h1);
    wb(1'b1, 8'h1c, 32'hffffffff, q);
    chk(8'h1c, 32'h0);
    wrap_up();
  end
endmodule : tb
bind cpu_subset_exec cpu_subset_chk #(.RESET_PC(RESET_PC), .IRQ_VECTOR(IRQ_VECTOR)) chk_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .irq_req(irq_req), .halted(halted));
`default_nettype wire
